//--- hw/pirq_pkg.sv
// Package for the peripheral interrupt status aggregator.
// Assumes an 8-bit register port with a 4-bit byte address.
package pirq_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned NUM_REQ = 16;

  // Register addresses
  localparam logic [3:0] ADDR_STAT_ONE   = 4'h0;
  localparam logic [3:0] ADDR_STAT_TWO   = 4'h1;
  localparam logic [3:0] ADDR_STAT_THREE = 4'h2;
  localparam logic [3:0] ADDR_SPI_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_SPI_FLAGS  = 4'h4;
  localparam logic [3:0] ADDR_SCI_CTRL   = 4'h5;
  localparam logic [3:0] ADDR_SCI_FLAGS  = 4'h6;
  localparam logic [3:0] ADDR_MISC_CTRL  = 4'h7;
  localparam logic [3:0] ADDR_MISC_FLAGS = 4'h8;

  // SPI control / flag bit positions
  localparam int unsigned SPI_RX_BIT    = 0;
  localparam int unsigned SPI_TX_BIT    = 1;
  localparam int unsigned SPI_FAULT_BIT = 2;
  localparam int unsigned SPI_MFEN_BIT  = 3;
  localparam int unsigned SPI_MSTR_BIT  = 4;
  localparam int unsigned SPI_OVF_BIT   = 3;

  // SCI bit positions, shared by enables and flags
  localparam int unsigned SCI_TXE_BIT  = 0;
  localparam int unsigned SCI_TXD_BIT  = 1;
  localparam int unsigned SCI_RXF_BIT  = 2;
  localparam int unsigned SCI_IDLE_BIT = 3;
  localparam int unsigned SCI_OVR_BIT  = 4;
  localparam int unsigned SCI_NF_BIT   = 5;
  localparam int unsigned SCI_FE_BIT   = 6;
  localparam int unsigned SCI_PE_BIT   = 7;

  // Misc control / flag bit positions
  localparam int unsigned KBD_BIT      = 0;
  localparam int unsigned ADC_BIT      = 1;
  localparam int unsigned TICK_BIT     = 2;
  localparam int unsigned TICK_ACK_BIT = 3;
  localparam int unsigned ADC_REQ_BIT  = 4;
  localparam int unsigned TSEL_LSB     = 4;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] FLAG_RST  = 8'h00;
  localparam logic [3:0] QCNT_RST  = 4'h0;

  // Idle line thresholds in consecutive ones
  localparam logic [3:0] QUIET_8BIT = 4'hA;
  localparam logic [3:0] QUIET_9BIT = 4'hB;

  // Tick divider: shortest period is 2**TICK_BASE cycles
  localparam int unsigned TICK_BASE = 4;

endpackage : pirq_pkg

//--- hw/pirq_agg.sv
// Peripheral interrupt status aggregator: source flags, enables, grouped
// request lines and three read-only pending status registers.
// Assumes event strobes come from logic on clk; pins are synchronised here.
`timescale 1ns/1ps

module pirq_agg
  import pirq_pkg::*;
#(
  parameter int unsigned TICK_W = 16
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic      [15:0]       cpu_req,
  input  wire logic [7:0]        ext_req,
  input  wire logic              spi_rx_xfer,
  input  wire logic              spi_tx_xfer,
  input  wire logic              spi_busy,
  input  wire logic              spi_ss_pin,
  input  wire logic              sci_tx_load,
  input  wire logic              sci_shift_empty,
  input  wire logic              sci_brk_idle,
  input  wire logic              sci_rx_xfer,
  input  wire logic              sci_rx_bit_stb,
  input  wire logic              sci_rx_bit,
  input  wire logic              sci_nine_bit,
  input  wire logic              sci_stop_stb,
  input  wire logic              sci_noise_ev,
  input  wire logic              sci_parity_ev,
  input  wire logic [7:0]        keypad_pins,
  input  wire logic              adc_conv_done
);

  function automatic logic [TICK_W-1:0] tick_mask(input logic [2:0] sel);
    logic [TICK_W-1:0] m;
    m = '0;
    for (int i = 0; i < TICK_W; i++) begin
      m[i] = (i < (TICK_BASE + int'(sel)));
    end
    return m;
  endfunction : tick_mask

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] at,
                                  input logic              w);
    return w && (a == at);
  endfunction : wr_hit

  logic [7:0]        spi_ctrl_r;
  logic [7:0]        sci_ctrl_r;
  logic [7:0]        misc_ctrl_r;
  logic [3:0]        spi_flags_r;
  logic [7:0]        sci_flags_r;
  logic              kbd_flag_r;
  logic              adc_done_flag_r;
  logic              adc_req_r;
  logic              tick_flag_r;
  logic [3:0]        quiet_cnt_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic [7:0]        kbd_s1_r;
  logic [7:0]        kbd_s2_r;
  logic              ss_s1_r;
  logic              ss_s2_r;
  logic              ss_s3_r;
  logic [15:0]       pending;
  logic [3:0]        quiet_thr;
  logic              quiet_hit;
  logic              tick_roll;
  logic              ss_rise;
  logic              spi_master;
  logic              mfen;
  logic              spi_mode_fault_flag_set;
  logic              txd_set;
  logic              tick_ack;
  logic [7:0]        spi_set;
  logic [7:0]        sci_set;
  logic [7:0]        spi_clr;
  logic [7:0]        sci_clr;
  logic [7:0]        misc_clr;

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kbd_s1_r <= 8'hff;
      kbd_s2_r <= 8'hff;
      ss_s1_r  <= 1'b1;
      ss_s2_r  <= 1'b1;
      ss_s3_r  <= 1'b1;
    end else if (ce) begin
      kbd_s1_r <= keypad_pins;
      kbd_s2_r <= kbd_s1_r;
      ss_s1_r  <= spi_ss_pin;
      ss_s2_r  <= ss_s1_r;
      ss_s3_r  <= ss_s2_r;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spi_ctrl_r  <= CTRL_RST;
      sci_ctrl_r  <= CTRL_RST;
      misc_ctrl_r <= CTRL_RST;
    end else if (ce) begin
      if (wr_hit(addr, ADDR_SPI_CTRL, wr)) begin
        spi_ctrl_r <= wdata;
      end
      if (wr_hit(addr, ADDR_SCI_CTRL, wr)) begin
        sci_ctrl_r <= wdata;
      end
      if (wr_hit(addr, ADDR_MISC_CTRL, wr)) begin
        misc_ctrl_r <= wdata;
      end
    end
  end

  assign spi_master = spi_ctrl_r[SPI_MSTR_BIT];
  assign mfen       = spi_ctrl_r[SPI_MFEN_BIT];
  assign ss_rise    = ss_s2_r && !ss_s3_r;
  assign spi_mode_fault_flag_set   = mfen && ((!spi_master && ss_rise && spi_busy)
                      || (spi_master && !ss_s2_r));

  // Write-one-to-clear masks; a set in the same cycle wins
  assign spi_clr  = wr_hit(addr, ADDR_SPI_FLAGS, wr)  ? wdata : 8'h00;
  assign sci_clr  = wr_hit(addr, ADDR_SCI_FLAGS, wr)  ? wdata : 8'h00;
  assign misc_clr = wr_hit(addr, ADDR_MISC_FLAGS, wr) ? wdata : 8'h00;
  assign tick_ack = misc_clr[TICK_ACK_BIT];

  always_comb begin
    spi_set = 8'h00;
    spi_set[SPI_RX_BIT]    = spi_rx_xfer;
    spi_set[SPI_TX_BIT]    = spi_tx_xfer;
    spi_set[SPI_FAULT_BIT] = spi_mode_fault_flag_set;
    spi_set[SPI_OVF_BIT]   = spi_rx_xfer && spi_flags_r[SPI_RX_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spi_flags_r <= FLAG_RST[3:0];
    end else if (ce) begin
      spi_flags_r <= (spi_flags_r & ~spi_clr[3:0]) | spi_set[3:0];
    end
  end

  // Idle line detector counts ones and fires once per quiet run
  assign quiet_thr = sci_nine_bit ? QUIET_9BIT : QUIET_8BIT;
  assign quiet_hit = sci_rx_bit_stb && sci_rx_bit
                     && (quiet_cnt_r == quiet_thr - 4'h1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt_r <= QCNT_RST;
    end else if (ce && sci_rx_bit_stb) begin
      if (!sci_rx_bit) begin
        quiet_cnt_r <= QCNT_RST;
      end else if (quiet_cnt_r < quiet_thr) begin
        quiet_cnt_r <= quiet_cnt_r + 4'h1;
      end
    end
  end

  // Data register empty is the tx empty flag; no break or idle in flight
  assign txd_set = sci_flags_r[SCI_TXE_BIT] && sci_shift_empty
                   && !sci_brk_idle && !sci_flags_r[SCI_TXD_BIT];

  always_comb begin
    sci_set = 8'h00;
    sci_set[SCI_TXE_BIT]  = sci_tx_load;
    sci_set[SCI_TXD_BIT]  = txd_set;
    sci_set[SCI_RXF_BIT]  = sci_rx_xfer;
    sci_set[SCI_IDLE_BIT] = quiet_hit;
    sci_set[SCI_OVR_BIT]  = sci_rx_xfer && sci_flags_r[SCI_RXF_BIT];
    sci_set[SCI_NF_BIT]   = sci_noise_ev;
    sci_set[SCI_FE_BIT]   = sci_stop_stb && !sci_rx_bit;
    sci_set[SCI_PE_BIT]   = sci_parity_ev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sci_flags_r <= FLAG_RST;
    end else if (ce) begin
      sci_flags_r <= (sci_flags_r & ~sci_clr) | sci_set;
    end
  end

  // Keypad flag is re-set every cycle a pin stays low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kbd_flag_r <= 1'b0;
    end else if (ce) begin
      kbd_flag_r <= (kbd_flag_r && !misc_clr[KBD_BIT])
                    || (kbd_s2_r != 8'hff);
    end
  end

  // Converter done: either a request or the plain done flag, never both
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_done_flag_r <= 1'b0;
      adc_req_r       <= 1'b0;
    end else if (ce) begin
      adc_done_flag_r <= (adc_done_flag_r && !misc_clr[ADC_BIT])
                         || (adc_conv_done && !misc_ctrl_r[ADC_BIT]);
      adc_req_r       <= (adc_req_r && !misc_clr[ADC_REQ_BIT])
                         || (adc_conv_done && misc_ctrl_r[ADC_BIT]);
    end
  end

  // Tick rate doubles the period per step of the select field
  assign tick_roll = &(tick_cnt_r | ~tick_mask(misc_ctrl_r[TSEL_LSB+:3]));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r  <= '0;
      tick_flag_r <= 1'b0;
    end else if (ce) begin
      tick_cnt_r  <= tick_cnt_r + 1'b1;
      tick_flag_r <= (tick_flag_r && !tick_ack) || tick_roll;
    end
  end

  // Request lines in fixed group order: external requests pass straight to 0-7, enabled flags ORed per line on 8-15
  always_comb begin
    pending        = 16'h0000;
    pending[7:0]   = ext_req;
    pending[8]     = (spi_flags_r[SPI_RX_BIT] && spi_ctrl_r[SPI_RX_BIT])
                     || ((spi_flags_r[SPI_FAULT_BIT]
                          || spi_flags_r[SPI_OVF_BIT])
                         && spi_ctrl_r[SPI_FAULT_BIT]);
    pending[9]     = spi_flags_r[SPI_TX_BIT] && spi_ctrl_r[SPI_TX_BIT];
    pending[10]    = |(sci_flags_r[7:4] & sci_ctrl_r[7:4]);
    pending[11]    = |(sci_flags_r[3:2] & sci_ctrl_r[3:2]);
    pending[12]    = |(sci_flags_r[1:0] & sci_ctrl_r[1:0]);
    pending[13]    = kbd_flag_r && misc_ctrl_r[KBD_BIT];
    pending[14]    = adc_req_r;
    pending[15]    = tick_flag_r && misc_ctrl_r[TICK_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_req <= 16'h0000;
    end else if (ce) begin
      cpu_req <= pending;
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          ADDR_STAT_ONE:   rdata <= {pending[5:0], 2'b00};
          ADDR_STAT_TWO:   rdata <= pending[13:6];
          ADDR_STAT_THREE: rdata <= {6'b00_0000, pending[15:14]};
          ADDR_SPI_CTRL:   rdata <= spi_ctrl_r;
          ADDR_SPI_FLAGS:  rdata <= {4'h0, spi_flags_r};
          ADDR_SCI_CTRL:   rdata <= sci_ctrl_r;
          ADDR_SCI_FLAGS:  rdata <= sci_flags_r;
          ADDR_MISC_CTRL:  rdata <= misc_ctrl_r;
          ADDR_MISC_FLAGS: rdata <= {3'b000, adc_req_r, 1'b0, tick_flag_r,
                                     adc_done_flag_r, kbd_flag_r};
          default:         rdata <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rd(logic [ADDR_W-1:0] a);
    ce && rd && addr == a;
  endsequence

  property p_spi_rx;
    ce && spi_rx_xfer |=> spi_flags_r[SPI_RX_BIT];
  endproperty
  a_spi_rx: assert property (p_spi_rx)
    else $error("spi rx full not set");

  property p_spi_tx;
    ce && spi_tx_xfer |=> spi_flags_r[SPI_TX_BIT];
  endproperty
  a_spi_tx: assert property (p_spi_tx)
    else $error("spi tx empty not set");

  property p_spi_mode_fault_flag_slave;
    ce && mfen && !spi_master && spi_busy && ss_rise
      |=> spi_flags_r[SPI_FAULT_BIT];
  endproperty
  a_spi_mode_fault_flag_slave: assert property (p_spi_mode_fault_flag_slave)
    else $error("slave mode fault missed");

  property p_spi_mode_fault_flag_master;
    ce && mfen && spi_master && !ss_s2_r |=> spi_flags_r[SPI_FAULT_BIT];
  endproperty
  a_spi_mode_fault_flag_master: assert property (p_spi_mode_fault_flag_master)
    else $error("master mode fault missed");

  property p_spi_ovf;
    ce && spi_rx_xfer && spi_flags_r[SPI_RX_BIT]
      |=> spi_flags_r[SPI_OVF_BIT];
  endproperty
  a_spi_ovf: assert property (p_spi_ovf)
    else $error("spi overflow not set");

  property p_quiet;
    ce && sci_rx_bit_stb && sci_rx_bit && !sci_nine_bit
      && quiet_cnt_r == 4'h9 |=> sci_flags_r[SCI_IDLE_BIT];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("idle line not flagged at ten ones");

  property p_kbd;
    ce && kbd_s2_r != 8'hff |=> kbd_flag_r;
  endproperty
  a_kbd: assert property (p_kbd)
    else $error("keypad low not latched");

  property p_tick_ack;
    ce && tick_ack && !tick_roll |=> !tick_flag_r ##1 !cpu_req[15];
  endproperty
  a_tick_ack: assert property (p_tick_ack)
    else $error("tick not cleared by ack");

  property p_stat_one;
    s_rd(ADDR_STAT_ONE) |=> rdata[1:0] == 2'b00
      && rdata[7:2] == $past(pending[5:0]);
  endproperty
  a_stat_one: assert property (p_stat_one)
    else $error("status one read wrong");

  property p_stat_three;
    s_rd(ADDR_STAT_THREE) |=> rdata[7:2] == 6'b00_0000;
  endproperty
  a_stat_three: assert property (p_stat_three)
    else $error("status three upper bits nonzero");

  property p_req_follow;
    ce ##1 ce |-> cpu_req == $past(pending);
  endproperty
  a_req_follow: assert property (p_req_follow)
    else $error("request lines do not follow flags");

endmodule : pirq_agg

//--- verification/pirq_cpu_model.sv
// CPU core model: acknowledges the periodic tick request by writing one to
// tick_ack after a chosen number of cycles, promptly or slowly.
// Assumes the bench multiplexes this write onto the register port.
`timescale 1ns/1ps
module pirq_cpu_model
  import pirq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ack_en,
  input  wire logic [3:0]        ack_dly,
  input  wire logic              tick_req,
  output logic                   wr,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata
);
  logic [3:0] wait_r;
  logic [1:0] cool_r;

  assign addr  = ADDR_MISC_FLAGS;
  assign wdata = 8'h01 << TICK_ACK_BIT;

  // Cool-down hides the registered request that lingers after an ack
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr     <= 1'b0;
      wait_r <= 4'h0;
      cool_r <= 2'h0;
    end else if (wr) begin
      wr     <= 1'b0;
      cool_r <= 2'h3;
    end else if (cool_r != 2'h0) begin
      cool_r <= cool_r - 2'h1;
    end else if (ack_en && tick_req) begin
      if (wait_r >= ack_dly) begin
        wr     <= 1'b1;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule : pirq_cpu_model

//--- verification/peripheral_irq_status_agg_tb_top.sv
// Testbench for the interrupt status aggregator: drives register port,
// event strobes and pins, and judges flags, status registers and requests.
// Assumes the package and design under hw/ and the CPU model beside it.
`timescale 1ns/1ps
module peripheral_irq_status_agg_tb_top;
  import pirq_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              b_wr = 1'b0;
  logic              rd = 1'b0;
  logic              m_wr;
  logic              wr;
  logic              auto = 1'b0;
  logic              ce = 1'b1;
  logic [3:0]        dly = 4'h0;
  logic [ADDR_W-1:0] b_addr = 4'h0;
  logic [ADDR_W-1:0] m_addr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] b_wdata = 8'h00;
  logic [DATA_W-1:0] m_wdata;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [15:0]       cpu_req;
  logic [7:0]        ext = 8'h00;
  logic [7:0]        kp = 8'hFF;
  logic [8:0]        ev = 9'h000;
  logic              busy = 1'b0;
  logic              ss = 1'b1;
  logic              se = 1'b0;
  logic              brk = 1'b0;
  logic              bstb = 1'b0;
  logic              rxb = 1'b1;
  logic              nine = 1'b0;
  int                fail_count = 0;
  int                tests_run = 0;
  int                cyc = 0;
  int                t0;

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // The model only writes while the bench keeps off the port
  assign addr  = m_wr ? m_addr : b_addr;
  assign wdata = m_wr ? m_wdata : b_wdata;
  assign wr    = b_wr | m_wr;

  pirq_agg dut_u (
    .clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_req(cpu_req), .ext_req(ext),
    .spi_rx_xfer(ev[0]), .spi_tx_xfer(ev[1]), .spi_busy(busy),
    .spi_ss_pin(ss), .sci_tx_load(ev[2]), .sci_shift_empty(se),
    .sci_brk_idle(brk), .sci_rx_xfer(ev[3]), .sci_rx_bit_stb(bstb),
    .sci_rx_bit(rxb), .sci_nine_bit(nine), .sci_stop_stb(ev[6]),
    .sci_noise_ev(ev[4]), .sci_parity_ev(ev[5]),
    .keypad_pins(kp & {7'h7F, ~ev[7]}), .adc_conv_done(ev[8]));

  pirq_cpu_model cpu_u (
    .clk(clk), .nrst(nrst), .ack_en(auto), .ack_dly(dly),
    .tick_req(cpu_req[15]), .wr(m_wr), .addr(m_addr), .wdata(m_wdata));

  task conclude;
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : cmp

  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    b_addr <= a;
    b_wdata <= d;
    b_wr <= 1'b1;
    @(posedge clk);
    b_wr <= 1'b0;
  endtask : wreg

  // Tick flag free-runs whatever the enable, so its bit is masked here
  task rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] g;
    @(posedge clk);
    b_addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    g = rdata & ((a == ADDR_MISC_FLAGS) ? 8'hFB : 8'hFF);
    cmp($sformatf("register %0d", a), {8'h00, e}, {8'h00, g});
  endtask : rchk

  task stat(input logic [15:0] e);
    rchk(ADDR_STAT_ONE, {e[5:0], 2'b00});
    rchk(ADDR_STAT_TWO, e[13:6]);
    rchk(ADDR_STAT_THREE, {6'h00, e[15:14]});
    cmp("cpu_req", e, cpu_req);
  endtask : stat

  task fire(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : fire

  task src(input logic [3:0] ea, input logic [7:0] em, input logic [3:0] fa,
           input logic [7:0] fx, input int e, input int n, input int g);
    wreg(fa, 8'hFF);
    repeat (n) fire(e);
    rchk(fa, fx);
    stat(16'h0000);
    wreg(ea, em);
    stat(16'h0001 << (g - 1));
    wreg(fa, 8'hFF);
    wreg(ea, 8'h00);
  endtask : src

  task bits(input int n, input logic v);
    repeat (n) begin
      @(posedge clk);
      rxb <= v;
      bstb <= 1'b1;
      @(posedge clk);
      bstb <= 1'b0;
    end
  endtask : bits

  task wlev(input logic v);
    int k;
    k = 0;
    while (cpu_req[15] !== v && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (k == 1000) begin
      cmp("tick wait", 16'h0001, 16'h0000);
      conclude();
    end
  endtask : wlev

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 10; a++) rchk(4'(a), 8'h00);
    wreg(ADDR_STAT_ONE, 8'hFF);
    wreg(4'h9, 8'hFF);
    rchk(4'h9, 8'h00);
    stat(16'h0000);
    ext <= 8'hA5;
    stat(16'h00A5);
    ext <= 8'h00;
    // Clock enable low must freeze flags and control registers alike
    ce <= 1'b0;
    fire(0);
    wreg(ADDR_SPI_CTRL, 8'hFF);
    ce <= 1'b1;
    rchk(ADDR_SPI_FLAGS, 8'h00);
    rchk(ADDR_SPI_CTRL, 8'h00);
    src(ADDR_SPI_CTRL, 8'h01, ADDR_SPI_FLAGS, 8'h01, 0, 1, 9);
    src(ADDR_SPI_CTRL, 8'h02, ADDR_SPI_FLAGS, 8'h02, 1, 1, 10);
    src(ADDR_SPI_CTRL, 8'h04, ADDR_SPI_FLAGS, 8'h09, 0, 2, 9);
    src(ADDR_SCI_CTRL, 8'h01, ADDR_SCI_FLAGS, 8'h01, 2, 1, 13);
    src(ADDR_SCI_CTRL, 8'h04, ADDR_SCI_FLAGS, 8'h04, 3, 1, 12);
    src(ADDR_SCI_CTRL, 8'h10, ADDR_SCI_FLAGS, 8'h14, 3, 2, 11);
    src(ADDR_SCI_CTRL, 8'h20, ADDR_SCI_FLAGS, 8'h20, 4, 1, 11);
    src(ADDR_SCI_CTRL, 8'h80, ADDR_SCI_FLAGS, 8'h80, 5, 1, 11);
    bits(1, 1'b0);
    src(ADDR_SCI_CTRL, 8'h40, ADDR_SCI_FLAGS, 8'h40, 6, 1, 11);
    src(ADDR_MISC_CTRL, 8'h01, ADDR_MISC_FLAGS, 8'h01, 7, 1, 14);
    for (int i = 0; i < 8; i++) begin
      kp <= ~(8'h01 << i);
      repeat (4) @(posedge clk);
      kp <= 8'hFF;
      rchk(ADDR_MISC_FLAGS, 8'h01);
      wreg(ADDR_MISC_FLAGS, 8'h01);
    end
    for (int n = 0; n < 2; n++) begin
      nine <= n[0];
      wreg(ADDR_SCI_CTRL, 8'h08);
      bits(1, 1'b0);
      wreg(ADDR_SCI_FLAGS, 8'hFF);
      bits(9 + n, 1'b1);
      rchk(ADDR_SCI_FLAGS, 8'h00);
      bits(1, 1'b1);
      rchk(ADDR_SCI_FLAGS, 8'h08);
      stat(16'h0800);
      wreg(ADDR_SCI_FLAGS, 8'hFF);
    end
    wreg(ADDR_SPI_CTRL, 8'h0C);
    busy <= 1'b1;
    ss <= 1'b0;
    rchk(ADDR_SPI_FLAGS, 8'h00);
    ss <= 1'b1;
    repeat (5) @(posedge clk);
    rchk(ADDR_SPI_FLAGS, 8'h04);
    stat(16'h0100);
    busy <= 1'b0;
    wreg(ADDR_SPI_FLAGS, 8'hFF);
    wreg(ADDR_SPI_CTRL, 8'h18);
    ss <= 1'b0;
    // Select pin needs two sync stages before the fault can set
    repeat (3) @(posedge clk);
    rchk(ADDR_SPI_FLAGS, 8'h04);
    stat(16'h0000);
    wreg(ADDR_SPI_CTRL, 8'h1C);
    stat(16'h0100);
    ss <= 1'b1;
    repeat (5) @(posedge clk);
    wreg(ADDR_SPI_FLAGS, 8'hFF);
    wreg(ADDR_SPI_CTRL, 8'h00);
    se <= 1'b1;
    brk <= 1'b1;
    wreg(ADDR_SCI_FLAGS, 8'hFF);
    fire(2);
    rchk(ADDR_SCI_FLAGS, 8'h01);
    brk <= 1'b0;
    rchk(ADDR_SCI_FLAGS, 8'h03);
    wreg(ADDR_SCI_CTRL, 8'h02);
    stat(16'h1000);
    se <= 1'b0;
    wreg(ADDR_SCI_FLAGS, 8'hFF);
    wreg(ADDR_SCI_CTRL, 8'h00);
    fire(8);
    rchk(ADDR_MISC_FLAGS, 8'h02);
    stat(16'h0000);
    wreg(ADDR_MISC_FLAGS, 8'hFF);
    wreg(ADDR_MISC_CTRL, 8'h02);
    fire(8);
    rchk(ADDR_MISC_FLAGS, 8'h10);
    stat(16'h4000);
    wreg(ADDR_MISC_FLAGS, 8'hFF);
    wreg(ADDR_MISC_CTRL, 8'h00);
    repeat (40) @(posedge clk);
    stat(16'h0000);
    wreg(ADDR_MISC_CTRL, 8'h04);
    repeat (40) @(posedge clk);
    cmp("tick held", 16'h0001, {15'h0000, cpu_req[15]});
    auto <= 1'b1;
    wlev(1'b0);
    for (int s = 0; s < 4; s++) begin
      auto <= 1'b0;
      dly <= 4'(3 * s);
      repeat (4) @(posedge clk);
      wreg(ADDR_MISC_CTRL, {1'b0, 3'(s), 4'h4});
      auto <= 1'b1;
      wlev(1'b0);
      wlev(1'b1);
      wlev(1'b0);
      wlev(1'b1);
      t0 = cyc;
      wlev(1'b0);
      wlev(1'b1);
      cmp("tick period", 16'(1 << (TICK_BASE + s)), 16'(cyc - t0));
    end
    auto <= 1'b0;
    conclude();
  end
endmodule : peripheral_irq_status_agg_tb_top
